/* fdec_fetch_model.sv */
// Purpose: Fetch unit and datapath stand-in that feeds the decoder.
// Assumes: The bench queues words; one word leaves per accepted fetch.
// Notes: An idle word line toggles every cycle, so stale data never passes as valid.
module fdec_fetch_model
    import fdec_pkg::*;
(
    input wire logic pclk,
    input wire logic instr_ready,
    output logic [15:0] instr_word,
    output logic instr_valid,
    output logic cond_true,
    output logic product_valid,
    output logic [15:0] product
);
    logic [15:0] words[$];
    logic cond;

    // ==========
    // Fetch and condition
    initial begin
        cond = 1'b0;
        instr_word = 16'h0000;
        instr_valid = 1'b0;
        cond_true = 1'b0;
        product_valid = 1'b0;
        product = 16'h0000;
    end

    always @(posedge pclk) begin
        if (instr_valid && instr_ready) begin
            void'(words.pop_front());
        end
        instr_valid <= (words.size() != 0);
        instr_word <= (words.size() != 0) ? words[0] : ~instr_word;
        cond_true <= cond;
    end

    task automatic give_product(input logic [15:0] v);
        @(posedge pclk);
        product_valid <= 1'b1;
        product <= v;
        @(posedge pclk);
        product_valid <= 1'b0;
        product <= ~v;
    endtask : give_product
endmodule : fdec_fetch_model

/* fdec_field_reg.sv */
// Purpose: One loadable register with a constant reset value.
// Assumes: Write enable and data come from logic on the same clock.
// Notes: Used for the run, bank, pointer, latch and product byte registers.
module fdec_field_reg
    import fdec_pkg::*;
#(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    output logic [W-1:0] q
);
    initial begin
        if (W < 1) $error("fdec_field_reg: width must be positive");
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= RST;
        end else if (wr_en) begin
            q <= wr_data;
        end
    end
endmodule : fdec_field_reg

/* fdec_phase.sv */
// Purpose: Divides the core clock into instruction cycles of several phases.
// Assumes: The phase count is four; any other value is flagged as an error and the two-bit counter always wraps at four.
// Notes: The count free runs from reset; no edge is ever skipped.
module fdec_phase
    import fdec_pkg::*;
#(
    parameter int N = PHASES
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic [1:0] phase,
    output logic cycle_start,
    output logic cycle_end
);
    initial begin
        if (N != 4) $error("fdec_phase: only four phases are supported");
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    assign cycle_start = (phase == 2'h0);
    assign cycle_end = (phase == PHASE_LAST);
endmodule : fdec_phase

/* fdec_pkg.sv */
// Purpose: Shared constants and types for the file register opcode decoder.
// Assumes: 16-bit instruction words and an APB register port with 32-bit data.
// Notes: Opcode prefixes are compared against slices of the word, top bit first.
package fdec_pkg;
    // ==========================================================
    // Timing
    localparam int PHASES = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    // ==========================================================
    // Field positions and widths
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    localparam int FAST_BIT = 8;
    localparam int BITPOS_LSB = 9;
    localparam logic [7:0] ACCESS_BANK = 8'h00;

    // ==========================================================
    // Opcode prefixes
    localparam logic [5:0] P6_ADD = 6'h09;
    localparam logic [5:0] P6_ADDC = 6'h08;
    localparam logic [5:0] P6_SUBFB = 6'h15;
    localparam logic [5:0] P6_SUB = 6'h17;
    localparam logic [5:0] P6_SUBB = 6'h16;
    localparam logic [5:0] P6_AND = 6'h05;
    localparam logic [5:0] P6_OR = 6'h04;
    localparam logic [5:0] P6_COM = 6'h07;
    localparam logic [5:0] P6_RLC = 6'h0D;
    localparam logic [5:0] P6_RRC = 6'h0C;
    localparam logic [5:0] P6_RLN = 6'h11;
    localparam logic [5:0] P6_RRN = 6'h10;
    localparam logic [5:0] P6_INCSZ = 6'h0F;
    localparam logic [5:0] P6_INCSNZ = 6'h12;
    localparam logic [6:0] P7_CPEQ = 7'h31;
    localparam logic [6:0] P7_CPGT = 7'h32;
    localparam logic [6:0] P7_CPLT = 7'h30;
    localparam logic [6:0] P7_MUL = 7'h01;
    localparam logic [6:0] P7_CALL = 7'h76;
    localparam logic [7:0] P8_JUMP = 8'hEF;
    localparam logic [4:0] P5_RJUMP = 5'h1A;
    localparam logic [4:0] P5_CBRANCH = 5'h1C;
    localparam logic [4:0] P5_LIT = 5'h01;
    localparam logic [3:0] OPC_FMOVE = 4'hC;
    localparam logic [3:0] OPC_SECOND = 4'hF;
    localparam logic [3:0] OPC_BITCLR = 4'h9;
    localparam logic [3:0] OPC_BTSC = 4'hB;

    // ==========================================================
    // Status flag masks: bit 0 carry, 1 nibble carry, 2 zero, 3 wrap, 4 negative
    localparam logic [4:0] FLAGS_ALL = 5'h1F;
    localparam logic [4:0] FLAGS_ZN = 5'h14;
    localparam logic [4:0] FLAGS_CZN = 5'h15;
    localparam logic [4:0] FLAGS_NONE = 5'h00;

    // ==========================================================
    // Register map and reset values
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BANK = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PMPTR = 8'h0C;
    localparam logic [7:0] REG_PMLATCH = 8'h10;
    localparam logic [7:0] REG_PHI = 8'h14;
    localparam logic [7:0] REG_PLO = 8'h18;
    localparam logic [0:0] RST_RUN = 1'h0;
    localparam logic [7:0] RST_BANK = 8'h00;
    localparam logic [20:0] RST_PMPTR = 21'h000000;
    localparam logic [7:0] RST_BYTE = 8'h00;

    typedef enum logic [4:0] {
        OP_NOP, OP_ADD, OP_ADDC, OP_SUBFB, OP_SUB, OP_SUBB, OP_AND, OP_OR,
        OP_COM, OP_RLC, OP_RRC, OP_RLN, OP_RRN, OP_CPEQ, OP_CPGT, OP_CPLT,
        OP_INCSZ, OP_INCSNZ, OP_MUL, OP_FMOVE, OP_BITCLR, OP_BTSC, OP_LIT,
        OP_JUMP, OP_CALL, OP_RJUMP, OP_CBRANCH
    } fdec_op_t;

    typedef enum logic {SEQ_EXEC, SEQ_SECOND} fdec_seq_t;

    typedef struct packed {
        fdec_op_t op;
        logic [3:0] subop;
        logic [7:0] file_addr;
        logic dest_file;
        logic bank_sel;
        logic [7:0] bank;
        logic [2:0] bit_pos;
        logic [7:0] literal;
        logic [19:0] target;
        logic fast;
        logic [10:0] offset;
        logic [11:0] src_addr;
        logic [11:0] dst_addr;
        logic [1:0] cycles;
        logic [4:0] flags;
    } fdec_ctrl_t;
endpackage : fdec_pkg

/* fdec_top.sv */
// Purpose: Decodes instruction words into control fields for the core datapath.
// Assumes: Fetch, datapath condition and product come from logic on pclk.
// Notes: One instruction cycle is four pclk periods; fields change at its end.
// Summary of operation
// [RULE_01] Byte file ops: low byte is file address; opcode, d and a above.
// [RULE_02] Destination bit zero selects accumulator, one selects the file register.
// [RULE_03] Access bit zero uses access bank; one takes bank from bank register.
// [RULE_04] File move: two words, nibble 1100 then 1111, twelve-bit addresses each.
// [RULE_05] Bit ops carry bit position, access bit, file address; clear is 1001.
// [RULE_06] Bit test skip: one cycle, two or three when skipping.
// [RULE_07] Literal ops hold eight-bit immediate in the low byte.
// [RULE_08] Jump and call build twenty-bit target over two words; call has fast bit.
// [RULE_09] Relative jump carries eleven-bit signed offset in one word.
// [RULE_10] Conditional branches carry eight-bit signed offset in the low byte.
// [RULE_11] Add and add with carry decode; one cycle; all five flags.
// [RULE_12] Three subtract forms decode and update all five arithmetic flags.
// [RULE_13] AND, OR, complement decode; one cycle; zero and negative only.
// [RULE_14] Carry rotates update carry, zero, negative; plain rotates in 0100 group.
// [RULE_15] Compare-and-skip forms in 0110 group; no flags; skip adds cycles.
// [RULE_16] Increment-skip forms honour destination, keep flags, skip conditionally.
// [RULE_17] Multiply decodes from 0000 001a, one cycle, no flags.
// [RULE_18] Core keeps 21-bit program memory pointer and 8-bit latch.
// [RULE_19] A lone word with top nibble all ones is a no-operation.
// [RULE_20] Cycle is four clocks; program counter change or true test adds NOP.
// [RULE_21] Multiply result goes to high and low product byte registers.
// [RULE_22] Control fields appear at cycle start and hold for the whole cycle.
module fdec_top
    import fdec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    output logic instr_ready,
    input wire logic cond_true,
    input wire logic product_valid,
    input wire logic [15:0] product,
    output fdec_ctrl_t ctrl,
    output logic ctrl_start,
    output logic [1:0] phase,
    output logic [20:0] program_memory_pointer,
    output logic [7:0] program_memory_latch,
    output logic [7:0] product_high_byte,
    output logic [7:0] product_low_byte
);
    // ==========================================================
    // Decode
    function automatic fdec_ctrl_t decode_word(input logic [15:0] w,
                                               input logic [7:0] bank);
        fdec_ctrl_t c;
        c = '0;
        c.op = OP_NOP;
        c.cycles = 2'h1;
        c.subop = w[11:8];
        c.file_addr = w[7:0]; // RULE_01
        c.dest_file = w[DEST_BIT]; // RULE_02
        c.bank_sel = w[ACCESS_BIT];
        c.bank = w[ACCESS_BIT] ? bank : ACCESS_BANK; // RULE_03
        c.bit_pos = w[BITPOS_LSB +: 3]; // RULE_05
        c.literal = w[7:0]; // RULE_07
        c.target = {12'h000, w[7:0]}; // RULE_08
        c.fast = w[FAST_BIT]; // RULE_08
        c.offset = w[10:0]; // RULE_09
        c.src_addr = w[11:0]; // RULE_04
        if (w[15:10] == P6_ADD) begin
            c.op = OP_ADD; // RULE_11
            c.flags = FLAGS_ALL;
        end else if (w[15:10] == P6_ADDC) begin
            c.op = OP_ADDC; // RULE_11
            c.flags = FLAGS_ALL;
        end else if (w[15:10] == P6_SUBFB) begin
            c.op = OP_SUBFB; // RULE_12
            c.flags = FLAGS_ALL;
        end else if (w[15:10] == P6_SUB) begin
            c.op = OP_SUB; // RULE_12
            c.flags = FLAGS_ALL;
        end else if (w[15:10] == P6_SUBB) begin
            c.op = OP_SUBB; // RULE_12
            c.flags = FLAGS_ALL;
        end else if (w[15:10] == P6_AND) begin
            c.op = OP_AND; // RULE_13
            c.flags = FLAGS_ZN;
        end else if (w[15:10] == P6_OR) begin
            c.op = OP_OR; // RULE_13
            c.flags = FLAGS_ZN;
        end else if (w[15:10] == P6_COM) begin
            c.op = OP_COM; // RULE_13
            c.flags = FLAGS_ZN;
        end else if (w[15:10] == P6_RLC) begin
            c.op = OP_RLC; // RULE_14
            c.flags = FLAGS_CZN;
        end else if (w[15:10] == P6_RRC) begin
            c.op = OP_RRC; // RULE_14
            c.flags = FLAGS_CZN;
        end else if (w[15:10] == P6_RLN) begin
            c.op = OP_RLN; // RULE_14
            c.flags = FLAGS_ZN;
        end else if (w[15:10] == P6_RRN) begin
            c.op = OP_RRN; // RULE_14
            c.flags = FLAGS_ZN;
        end else if (w[15:10] == P6_INCSZ) begin
            c.op = OP_INCSZ; // RULE_16
        end else if (w[15:10] == P6_INCSNZ) begin
            c.op = OP_INCSNZ; // RULE_16
        end else if (w[15:9] == P7_CPEQ) begin
            c.op = OP_CPEQ; // RULE_15
        end else if (w[15:9] == P7_CPGT) begin
            c.op = OP_CPGT; // RULE_15
        end else if (w[15:9] == P7_CPLT) begin
            c.op = OP_CPLT; // RULE_15
        end else if (w[15:9] == P7_MUL) begin
            c.op = OP_MUL; // RULE_17
        end else if (w[15:12] == OPC_FMOVE) begin
            c.op = OP_FMOVE; // RULE_04
            c.cycles = 2'h2;
        end else if (w[15:12] == OPC_BITCLR) begin
            c.op = OP_BITCLR; // RULE_05
        end else if (w[15:12] == OPC_BTSC) begin
            c.op = OP_BTSC; // RULE_06
        end else if (w[15:11] == P5_LIT) begin
            c.op = OP_LIT; // RULE_07
        end else if (w[15:8] == P8_JUMP) begin
            c.op = OP_JUMP; // RULE_08
            c.cycles = 2'h2;
        end else if (w[15:9] == P7_CALL) begin
            c.op = OP_CALL; // RULE_08
            c.cycles = 2'h2;
        end else if (w[15:11] == P5_RJUMP) begin
            c.op = OP_RJUMP; // RULE_09
            c.cycles = 2'h2;
        end else if (w[15:11] == P5_CBRANCH) begin
            c.op = OP_CBRANCH; // RULE_10
            c.offset = {{3{w[7]}}, w[7:0]};
        end
        // A word with the top nibble all ones falls through to no-operation.
        return c; // RULE_19
    endfunction : decode_word

    // ==========================================================
    // Phase generation
    logic cycle_start;
    logic cycle_end;

    fdec_phase #(.N(PHASES)) u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .phase(phase),
        .cycle_start(cycle_start),
        .cycle_end(cycle_end)
    );

    // ==========================================================
    // Register port
    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite;
    wire hit_ctrl = (paddr == REG_CTRL);
    wire hit_bank = (paddr == REG_BANK);
    wire hit_status = (paddr == REG_STATUS);
    wire hit_pmptr = (paddr == REG_PMPTR);
    wire hit_pmlatch = (paddr == REG_PMLATCH);
    wire hit_phi = (paddr == REG_PHI);
    wire hit_plo = (paddr == REG_PLO);
    wire hit_any = hit_ctrl | hit_bank | hit_status | hit_pmptr | hit_pmlatch
                   | hit_phi | hit_plo;

    logic [0:0] run_reg;
    logic [7:0] bank_select_reg;
    logic [31:0] prdata_next;
    fdec_seq_t seq_reg;
    fdec_seq_t seq_next;
    fdec_ctrl_t ctrl_reg;
    fdec_ctrl_t ctrl_next;
    fdec_ctrl_t first_reg;
    fdec_ctrl_t first_next;
    logic discard_reg;
    logic discard_next;

    fdec_field_reg #(.W(1), .RST(RST_RUN)) u_run (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(apb_wr && hit_ctrl),
        .wr_data(pwdata[0:0]),
        .q(run_reg)
    );

    fdec_field_reg #(.W(8), .RST(RST_BANK)) u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(apb_wr && hit_bank),
        .wr_data(pwdata[7:0]),
        .q(bank_select_reg)
    );

    // Pointer and latch are plain storage here, written only through the register port.
    fdec_field_reg #(.W(21), .RST(RST_PMPTR)) u_pmptr ( // RULE_18
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(apb_wr && hit_pmptr),
        .wr_data(pwdata[20:0]),
        .q(program_memory_pointer)
    );

    fdec_field_reg #(.W(8), .RST(RST_BYTE)) u_pmlatch ( // RULE_18
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(apb_wr && hit_pmlatch),
        .wr_data(pwdata[7:0]),
        .q(program_memory_latch)
    );

    // Product bytes are loaded only by the datapath; software sees them read only.
    fdec_field_reg #(.W(8), .RST(RST_BYTE)) u_phi ( // RULE_21
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(product_valid),
        .wr_data(product[15:8]),
        .q(product_high_byte)
    );

    fdec_field_reg #(.W(8), .RST(RST_BYTE)) u_plo ( // RULE_21
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(product_valid),
        .wr_data(product[7:0]),
        .q(product_low_byte)
    );

    always_comb begin
        prdata_next = 32'h00000000;
        if (hit_ctrl) prdata_next = {31'h00000000, run_reg};
        if (hit_bank) prdata_next = {24'h000000, bank_select_reg};
        if (hit_status) prdata_next = {19'h00000, ctrl_reg.op, 6'h00,
                                       discard_reg, seq_reg == SEQ_SECOND};
        if (hit_pmptr) prdata_next = {11'h000, program_memory_pointer};
        if (hit_pmlatch) prdata_next = {24'h000000, program_memory_latch};
        if (hit_phi) prdata_next = {24'h000000, product_high_byte};
        if (hit_plo) prdata_next = {24'h000000, product_low_byte};
    end

    // Read data is captured in the setup cycle so that no wait state is needed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (apb_setup) begin
            prdata <= prdata_next;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    // ==========================================================
    // Sequencing
    wire fdec_ctrl_t dec = decode_word(instr_word, bank_select_reg);
    wire fdec_ctrl_t nop_ctrl = decode_word(16'h0000, bank_select_reg);
    wire take = cycle_end && run_reg[0] && instr_valid;
    wire is_cond = (ctrl_reg.op == OP_CBRANCH) || (ctrl_reg.op == OP_BTSC)
                   || (ctrl_reg.op == OP_CPEQ) || (ctrl_reg.op == OP_CPGT)
                   || (ctrl_reg.op == OP_CPLT) || (ctrl_reg.op == OP_INCSZ)
                   || (ctrl_reg.op == OP_INCSNZ);
    wire is_jump = (ctrl_reg.op == OP_RJUMP) || (ctrl_reg.op == OP_JUMP)
                   || (ctrl_reg.op == OP_CALL);
    wire exec_change = cycle_end && (is_jump || (is_cond && cond_true)); // RULE_20
    wire discard_now = discard_reg || exec_change;
    wire two_word = (dec.op == OP_FMOVE) || (dec.op == OP_JUMP) || (dec.op == OP_CALL);

    fdec_ctrl_t joined;
    always_comb begin
        joined = first_reg;
        joined.target[19:8] = instr_word[11:0]; // RULE_08
        joined.dst_addr = instr_word[11:0]; // RULE_04
    end

    // A skipped two-word instruction leaves its second word to run as a NOP on
    // its own, which yields the three-cycle skip without extra state.
    always_comb begin
        ctrl_next = ctrl_reg;
        seq_next = seq_reg;
        first_next = first_reg;
        discard_next = discard_reg || exec_change;
        if (cycle_end) begin
            ctrl_next = nop_ctrl;
            if (take) begin
                discard_next = 1'b0;
                if (discard_now) begin
                    seq_next = SEQ_EXEC; // RULE_06
                end else if (seq_reg == SEQ_SECOND) begin
                    ctrl_next = joined; // RULE_04
                    seq_next = SEQ_EXEC;
                end else if (two_word) begin
                    first_next = dec;
                    seq_next = SEQ_SECOND;
                end else begin
                    ctrl_next = dec;
                end
            end
        end
    end

    // Fields change only at the end of a cycle, so they hold for a whole cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= '0;
            seq_reg <= SEQ_EXEC;
            first_reg <= '0;
            discard_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next; // RULE_22
            seq_reg <= seq_next;
            first_reg <= first_next;
            discard_reg <= discard_next;
        end
    end

    assign ctrl = ctrl_reg;
    assign ctrl_start = cycle_start;
    assign instr_ready = cycle_end && run_reg[0];

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_take_exec;
        take && (seq_reg == SEQ_EXEC) && !discard_now;
    endsequence

    AST_CTRL_STABLE: assert property (!cycle_end |=> $stable(ctrl_reg)) // RULE_22
        else $error("control fields changed inside a cycle");
    AST_PHASE_FOUR: assert property (cycle_start |-> !cycle_end [*3] ##1 cycle_end) // RULE_20
        else $error("instruction cycle is not four clocks");
    AST_DISCARD: assert property (take && exec_change |=> ctrl_reg.op == OP_NOP) // RULE_20
        else $error("word after a taken change was not replaced by a NOP");
    AST_FILE_ADDR: assert property (s_take_exec and !two_word |=>
        ctrl_reg.file_addr == $past(instr_word[7:0])) // RULE_01
        else $error("file address not taken from the low byte");
    AST_BANK: assert property (!ctrl_reg.bank_sel |-> ctrl_reg.bank == ACCESS_BANK) // RULE_03
        else $error("access bank not forced");
    AST_TWO_WORD: assert property (s_take_exec and dec.op == OP_FMOVE |=>
        seq_reg == SEQ_SECOND && ctrl_reg.op == OP_NOP) // RULE_04
        else $error("file move did not wait for its second word");
    AST_TARGET: assert property (take && seq_reg == SEQ_SECOND && !discard_now |=>
        ctrl_reg.target[19:8] == $past(instr_word[11:0])) // RULE_08
        else $error("upper target bits not from the second word");
    AST_LONE_SECOND: assert property (s_take_exec and instr_word[15:12] == OPC_SECOND
        |=> ctrl_reg.op == OP_NOP) // RULE_19
        else $error("lone second word did not act as a NOP");
    AST_MUL_FLAGS: assert property (ctrl_reg.op == OP_MUL |-> ctrl_reg.flags == FLAGS_NONE) // RULE_17
        else $error("multiply marked as changing flags");
    AST_PRODUCT: assert property (product_valid |=>
        {product_high_byte, product_low_byte} == $past(product)) // RULE_21
        else $error("product bytes not loaded");
endmodule : fdec_top

/* tb.sv */
// Purpose: Self-checking bench for the opcode decoder.
// Assumes: Zero-wait APB slave; fields change only at instruction cycle ends.
// Notes: Words are queued at phase 2, so each step sees the next word in order.
module tb
    import fdec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, instr_valid, instr_ready, cond_true, product_valid, ctrl_start;
    logic [15:0] instr_word, product;
    logic [1:0] phase;
    logic [20:0] program_memory_pointer;
    logic [7:0] program_memory_latch, product_high_byte, product_low_byte;
    fdec_ctrl_t ctrl, held;
    int n_errors = 0;
    int tests_run = 0;
    logic [15:0] tw[16] = '{16'h5400, 16'h5C00, 16'h5800, 16'h1400, 16'h1000, 16'h1C00,
        16'h3400, 16'h3000, 16'h4400, 16'h4000, 16'h3C00, 16'h4800, 16'h6200, 16'h6400,
        16'h6000, 16'h0200};
    fdec_op_t to[16] = '{OP_SUBFB, OP_SUB, OP_SUBB, OP_AND, OP_OR, OP_COM, OP_RLC, OP_RRC,
        OP_RLN, OP_RRN, OP_INCSZ, OP_INCSNZ, OP_CPEQ, OP_CPGT, OP_CPLT, OP_MUL};
    logic [4:0] tf[16] = '{5'h1F, 5'h1F, 5'h1F, 5'h14, 5'h14, 5'h14, 5'h15, 5'h15, 5'h14,
        5'h14, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};

    always #2.5 pclk = ~pclk;

    fdec_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .instr_word, .instr_valid, .instr_ready, .cond_true, .product_valid,
        .product, .ctrl, .ctrl_start, .phase, .program_memory_pointer, .program_memory_latch,
        .product_high_byte, .product_low_byte);
    fdec_fetch_model u_fetch (.pclk, .instr_ready, .instr_word, .instr_valid, .cond_true,
        .product_valid, .product);

    // ==========
    // Tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(n, e, rd);
    endtask : rchk

    task automatic push(input logic [15:0] w);
        u_fetch.words.push_back(w);
    endtask : push

    // Waits for the next cycle start, checks it, then returns at phase 2.
    task automatic step(input fdec_op_t op, input logic [4:0] fl, input logic [1:0] cy);
        int k;
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (ctrl_start !== 1'b1 && k < 20);
        if (ctrl_start !== 1'b1) n_errors++;
        held = ctrl;
        chk("phase", 32'h0, phase);
        chk("op", op, ctrl.op);
        if (cy != 2'h0) begin
            chk("flags", fl, ctrl.flags);
            chk("cycles", cy, ctrl.cycles);
        end
        repeat (2) @(negedge pclk);
        chk("held", 32'h1, ctrl === held);
    endtask : step

    task automatic dec(input logic [15:0] w, input fdec_op_t op, input logic [4:0] fl,
        input logic [1:0] cy);
        push(w);
        step(op, fl, cy);
    endtask : dec

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // ==========
    // Tests
    initial begin
        #20000;
        n_errors++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ctrl", REG_CTRL, 32'h00000000);
        rchk("pmptr", REG_PMPTR, 32'h00000000);
        apb(1'b1, REG_PMPTR, 32'hFFFFFFFF);
        rchk("pmptr", REG_PMPTR, 32'h001FFFFF);
        apb(1'b1, REG_PMLATCH, 32'hFFFFFFFF);
        rchk("pmlatch", REG_PMLATCH, 32'h000000FF);
        chk("okay", 32'h0, err);
        rchk("unmapped", 8'h40, 32'h00000000);
        chk("slverr", 32'h1, err);
        u_fetch.give_product(16'hABCD);
        apb(1'b1, REG_PHI, 32'h00000000);
        rchk("phi", REG_PHI, 32'h000000AB);
        rchk("plo", REG_PLO, 32'h000000CD);
        $display("test registers done");
        apb(1'b1, REG_BANK, 32'h0000005A);
        apb(1'b1, REG_CTRL, 32'h00000001);
        step(OP_NOP, 5'h00, 2'h0);
        dec(16'h2612, OP_ADD, FLAGS_ALL, 2'h1);
        chk("file", 32'h12, ctrl.file_addr);
        chk("dest", 32'h1, ctrl.dest_file);
        chk("bank", 32'h00, ctrl.bank);
        dec(16'h2100, OP_ADDC, FLAGS_ALL, 2'h1);
        chk("dest", 32'h0, ctrl.dest_file);
        chk("bank", 32'h5A, ctrl.bank);
        foreach (tw[i]) begin
            dec(tw[i], to[i], tf[i], 2'h1);
        end
        dec(16'h9A34, OP_BITCLR, FLAGS_NONE, 2'h1);
        chk("bitpos", 32'h5, ctrl.bit_pos);
        dec(16'h0E7F, OP_LIT, FLAGS_NONE, 2'h1);
        chk("literal", 32'h7F, ctrl.literal);
        dec(16'hE2F0, OP_CBRANCH, FLAGS_NONE, 2'h1);
        chk("offset", 32'h7F0, ctrl.offset);
        dec(16'hF123, OP_NOP, 5'h00, 2'h0);
        $display("test single done");
        push(16'hC123);
        dec(16'hF456, OP_NOP, 5'h00, 2'h0);
        step(OP_FMOVE, FLAGS_NONE, 2'h2);
        chk("src", 32'h123, ctrl.src_addr);
        chk("dst", 32'h456, ctrl.dst_addr);
        push(16'hED12);
        push(16'hF345);
        dec(16'h2612, OP_NOP, 5'h00, 2'h0);
        step(OP_CALL, FLAGS_NONE, 2'h2);
        chk("target", 32'h34512, ctrl.target);
        chk("fast", 32'h1, ctrl.fast);
        step(OP_NOP, 5'h00, 2'h0);
        push(16'hD3FF);
        dec(16'h2612, OP_RJUMP, FLAGS_NONE, 2'h2);
        chk("offset", 32'h3FF, ctrl.offset);
        step(OP_NOP, 5'h00, 2'h0);
        $display("test multi done");
        u_fetch.cond = 1'b1;
        push(16'hB000);
        dec(16'h2612, OP_BTSC, FLAGS_NONE, 2'h1);
        step(OP_NOP, 5'h00, 2'h0);
        push(16'h6201);
        push(16'hC123);
        push(16'hF456);
        dec(16'h2612, OP_CPEQ, FLAGS_NONE, 2'h1);
        step(OP_NOP, 5'h00, 2'h0);
        u_fetch.cond = 1'b0;
        step(OP_NOP, 5'h00, 2'h0);
        step(OP_ADD, FLAGS_ALL, 2'h1);
        $display("test skip done");
        print_verdict();
    end
endmodule : tb
